/* File: src/tpm_pkg.sv */
// package of the two-port terminal multiplexer channel logic
// assumes one 10 MHz clock shared by both ends of the channel
package tpm_pkg;
    localparam int unsigned tpm_word_w = 12;
    localparam int unsigned tpm_buf_depth = 64;
    localparam int unsigned tpm_ptr_w = 7;
    // function code fields (octal codes written in hex)
    localparam logic [2:0] tpm_terminal_select_code = 3'h7;
    localparam logic [2:0] tpm_terminal_deselect_code = 3'h6;
    localparam logic [2:0] tpm_operation_code = 3'h0;
    localparam logic [2:0] tpm_status_summary_read_code = 3'h0;
    localparam logic [2:0] tpm_terminal_data_read_code = 3'h1;
    localparam logic [2:0] tpm_output_buffer_write_code = 3'h2;
    localparam logic [11:0] tpm_select_port0 = 12'he00;
    localparam logic [11:0] tpm_select_port1 = 12'he01;
    // word bit numbers 52..63 map onto channel bits 11..0
    localparam int unsigned tpm_bit_base = 63;
    localparam int unsigned tpm_st_buf_not_full = tpm_bit_base - 59;
    localparam int unsigned tpm_st_input_ready = tpm_bit_base - 60;
    localparam int unsigned tpm_st_carrier = tpm_bit_base - 61;
    localparam int unsigned tpm_st_dsr = tpm_bit_base - 62;
    localparam int unsigned tpm_st_ring = tpm_bit_base - 63;
    localparam int unsigned tpm_rd_dsr = tpm_bit_base - 52;
    localparam int unsigned tpm_rd_dsr_dcd = tpm_bit_base - 53;
    localparam int unsigned tpm_rd_overrun = tpm_bit_base - 54;
    localparam int unsigned tpm_rd_error = tpm_bit_base - 55;
    // host register map (word index)
    localparam logic [3:0] tpm_reg_ctrl = 4'h0;
    localparam logic [3:0] tpm_reg_wdata = 4'h1;
    localparam logic [3:0] tpm_reg_status = 4'h2;
    localparam logic [3:0] tpm_reg_rdata = 4'h3;
    localparam logic [3:0] tpm_reg_irq_stat = 4'h4;
    localparam logic [3:0] tpm_reg_irq_mask = 4'h5;
    localparam int unsigned tpm_irq_w = 3;
    localparam int unsigned tpm_irq_done = 0;
    localparam int unsigned tpm_irq_input = 1;
    localparam int unsigned tpm_irq_stop = 2;
    localparam logic [2:0] tpm_irq_mask_reset = 3'h0;
    typedef enum logic [1:0] {
        tpm_cmd_function = 2'h0,
        tpm_cmd_input = 2'h1,
        tpm_cmd_output = 2'h2,
        tpm_cmd_disconnect = 2'h3
    } tpm_cmd_type;
endpackage

/* File: src/tpm_chan_if.sv */
// channel between the peripheral processor end and the multiplexer end
// assumes both ends on ref_clk; the pulses are one cycle wide
`timescale 1ns/10ps
interface tpm_chan_if;
    logic [11:0] data_pp;
    logic [11:0] data_mux;
    logic data_mux_oe;
    logic function_p;
    logic active_p;
    logic inactive_pp;
    logic full_pp;
    logic empty_pp;
    logic inactive_mux;
    logic full_mux;
    logic empty_mux;
    logic mux_drive;
    modport pp (output data_pp, function_p, active_p, inactive_pp, full_pp, empty_pp,
        input data_mux, data_mux_oe, inactive_mux, full_mux, empty_mux, mux_drive);
    modport mux (input data_pp, function_p, active_p, inactive_pp, full_pp, empty_pp,
        output data_mux, data_mux_oe, inactive_mux, full_mux, empty_mux, mux_drive);
endinterface

/* File: src/tpm_mux.sv */
// multiplexer end: function decode, status and data words, output buffer
// assumes a uart beside it delivering received characters and taking characters out
//
// Summary of operation
// - code 7000 picks port 0, 7001 port 1
// - deselect code frees the channel
// - status code: one 12-bit status word input
// - status bits 59..63: notfull,ready,dcd,dsr,ring
// - data read: processor activates, inputs one word
// - data bit 52 follows data set ready
// - data bit 53 is dsr and dcd
// - data bit 54 flags overrun
// - data bit 55 flags framing or parity
// - data bits 56..63 hold received character
// - write code opens 64-character output buffer
// - processor activates before sending words
// - inactive from processor ends buffer write
// - last free slot answered inactive, not empty
// - acknowledge 7 codes always, 6 and 0 codes only while selected; ignore others
// - new character overwrites unread one
// - each full word answered with empty, except the one taking the last free slot
`timescale 1ns/10ps
module tpm_mux (
    input wire logic ref_clk,
    input wire logic rst,
    tpm_chan_if.mux chan,
    input wire logic [1:0] dsr,
    input wire logic [1:0] dcd,
    input wire logic [1:0] ring,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_frame_err,
    input wire logic rx_parity_err,
    output logic [1:0] tx_valid,
    output logic [7:0] tx_char,
    input wire logic [1:0] tx_ready,
    output logic port_sel
);
    typedef enum logic [4:0] {
        tpm_st_idle = 5'h01,
        tpm_st_status = 5'h02,
        tpm_st_read = 5'h04,
        tpm_st_write = 5'h08,
        tpm_st_off = 5'h10
    } tpm_op_type;

    tpm_op_type op_r;
    logic selected_r;
    logic port_r;
    logic [1:0] dsr_s1_r, dsr_r, dcd_s1_r, dcd_r, ring_s1_r, ring_r;
    logic [7:0] rx_char_r;
    logic rx_full_r, overrun_r, rx_err_r;
    logic [7:0] buf_mem [0:tpm_pkg::tpm_buf_depth-1];
    logic [5:0] wr_ptr_r, rd_ptr_r;
    logic [6:0] count_r;
    logic [11:0] data_r;
    logic oe_r, full_r, empty_r, inactive_r;
    logic [2:0] code;
    logic ack_code, buf_full, buf_push, word_taken, last_slot;

    assign code = chan.data_pp[11:9];
    // deselected only a select code is heard
    assign ack_code = chan.function_p && (code == tpm_pkg::tpm_terminal_select_code ||
        (selected_r && (code == tpm_pkg::tpm_terminal_deselect_code ||
        code == tpm_pkg::tpm_operation_code)));
    assign buf_full = count_r == 7'(tpm_pkg::tpm_buf_depth);
    assign last_slot = count_r == 7'(tpm_pkg::tpm_buf_depth - 1);
    assign buf_push = op_r == tpm_st_write && chan.full_pp && !buf_full;
    assign word_taken = chan.empty_pp && oe_r;

    ////////////////////////////////////////////////////////////////
    // modem lines come from pins: two stages each
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dsr_s1_r <= 2'h0;
            dsr_r <= 2'h0;
            dcd_s1_r <= 2'h0;
            dcd_r <= 2'h0;
            ring_s1_r <= 2'h0;
            ring_r <= 2'h0;
        end else begin
            dsr_s1_r <= dsr;
            dsr_r <= dsr_s1_r;
            dcd_s1_r <= dcd;
            dcd_r <= dcd_s1_r;
            ring_s1_r <= ring;
            ring_r <= ring_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // selection
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            selected_r <= 1'b0;
            port_r <= 1'b0;
        end else if (ack_code) begin
            if (chan.data_pp == tpm_pkg::tpm_select_port0 ||
                chan.data_pp == tpm_pkg::tpm_select_port1) begin
                selected_r <= 1'b1;
                port_r <= chan.data_pp[0];
            end else if (code == tpm_pkg::tpm_terminal_deselect_code) begin
                selected_r <= 1'b0;
            end
        end
    end
    assign port_sel = port_r;

    ////////////////////////////////////////////////////////////////
    // operation sequencing
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_r <= tpm_st_idle;
        end else if (ack_code) begin
            if (code == tpm_pkg::tpm_operation_code && selected_r) begin
                case (chan.data_pp[8:6])
                    tpm_pkg::tpm_status_summary_read_code: op_r <= tpm_st_status;
                    tpm_pkg::tpm_terminal_data_read_code: op_r <= tpm_st_read;
                    tpm_pkg::tpm_output_buffer_write_code: op_r <= tpm_st_write;
                    default: op_r <= tpm_st_idle;
                endcase
            end else begin
                op_r <= tpm_st_idle;
            end
        end else begin
            case (op_r)
                tpm_st_status, tpm_st_read: begin
                    // one word input then done
                    if (word_taken || chan.inactive_pp)
                        op_r <= tpm_st_idle;
                end
                tpm_st_write: begin
                    if (chan.inactive_pp)
                        op_r <= tpm_st_idle;
                    else if (buf_push && last_slot)
                        op_r <= tpm_st_off;
                end
                tpm_st_off: op_r <= tpm_st_idle;
                tpm_st_idle: op_r <= tpm_st_idle;
                default: op_r <= tpm_st_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // receive holding register, no queue
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_char_r <= 8'h00;
            rx_full_r <= 1'b0;
            overrun_r <= 1'b0;
            rx_err_r <= 1'b0;
        end else if (rx_valid) begin
            rx_char_r <= rx_char;
            rx_full_r <= 1'b1;
            overrun_r <= rx_full_r;
            rx_err_r <= rx_frame_err | rx_parity_err;
        end else if (op_r == tpm_st_read && word_taken) begin
            rx_full_r <= 1'b0;
            overrun_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // output buffer; drains to the selected terminal's transmitter
    always_ff @(posedge ref_clk) begin
        if (buf_push)
            buf_mem[wr_ptr_r] <= chan.data_pp[7:0];
    end
    logic drain;
    assign drain = count_r != 7'h00 && tx_ready[port_r];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= 6'h00;
            rd_ptr_r <= 6'h00;
            count_r <= 7'h00;
        end else begin
            if (buf_push)
                wr_ptr_r <= wr_ptr_r + 6'h01;
            if (drain)
                rd_ptr_r <= rd_ptr_r + 6'h01;
            count_r <= count_r + {6'h00, buf_push} - {6'h00, drain};
        end
    end
    always_comb begin
        tx_valid = 2'h0;
        tx_valid[port_r] = count_r != 7'h00;
    end
    assign tx_char = buf_mem[rd_ptr_r];

    ////////////////////////////////////////////////////////////////
    // channel answers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_r <= 12'h000;
            oe_r <= 1'b0;
            full_r <= 1'b0;
            empty_r <= 1'b0;
            inactive_r <= 1'b0;
        end else begin
            full_r <= 1'b0;
            empty_r <= 1'b0;
            inactive_r <= ack_code;
            if (!selected_r || word_taken || chan.inactive_pp) begin
                oe_r <= 1'b0;
            end else if (chan.active_p && !oe_r && op_r == tpm_st_status) begin
                data_r <= 12'h000;
                data_r[tpm_pkg::tpm_st_buf_not_full] <= !buf_full;
                data_r[tpm_pkg::tpm_st_input_ready] <= rx_full_r;
                data_r[tpm_pkg::tpm_st_carrier] <= dcd_r[port_r];
                data_r[tpm_pkg::tpm_st_dsr] <= dsr_r[port_r];
                data_r[tpm_pkg::tpm_st_ring] <= ring_r[port_r];
                oe_r <= 1'b1;
                full_r <= 1'b1;
            end else if (chan.active_p && !oe_r && op_r == tpm_st_read) begin
                data_r[tpm_pkg::tpm_rd_dsr] <= dsr_r[port_r];
                data_r[tpm_pkg::tpm_rd_dsr_dcd] <= dsr_r[port_r] & dcd_r[port_r];
                data_r[tpm_pkg::tpm_rd_overrun] <= overrun_r;
                data_r[tpm_pkg::tpm_rd_error] <= rx_err_r;
                data_r[7:0] <= rx_char_r;
                oe_r <= 1'b1;
                full_r <= 1'b1;
            end
            if (buf_push) begin
                if (last_slot)
                    inactive_r <= 1'b1;
                else
                    empty_r <= 1'b1;
            end
        end
    end
    assign chan.data_mux = data_r;
    assign chan.data_mux_oe = oe_r;
    assign chan.full_mux = full_r;
    assign chan.empty_mux = empty_r;
    assign chan.inactive_mux = inactive_r;
    assign chan.mux_drive = selected_r;
endmodule

/* File: src/tpm_pp.sv */
// processor end: turns register commands into channel sequences
// assumes the multiplexer answers within a bounded number of cycles
`timescale 1ns/10ps
module tpm_pp (
    input wire logic ref_clk,
    input wire logic rst,
    tpm_chan_if.pp chan,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);
    typedef enum logic [3:0] {
        tpm_pp_idle = 4'h1,
        tpm_pp_wait_ack = 4'h2,
        tpm_pp_wait_in = 4'h4,
        tpm_pp_wait_out = 4'h8
    } tpm_pp_type;

    tpm_pp_type st_r;
    logic [11:0] out_r, in_r;
    logic busy_r, stopped_r;
    logic fn_r, act_r, inact_r, full_r, empty_r;
    logic [2:0] irq_stat_r, irq_mask_r, ev;
    logic [1:0] cmd;

    assign cmd = wdata[13:12];

    ////////////////////////////////////////////////////////////////
    // channel sequencer: one command at a time
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= tpm_pp_idle;
            out_r <= 12'h000;
            in_r <= 12'h000;
            busy_r <= 1'b0;
            stopped_r <= 1'b0;
            fn_r <= 1'b0;
            act_r <= 1'b0;
            inact_r <= 1'b0;
            full_r <= 1'b0;
            empty_r <= 1'b0;
            ev <= 3'h0;
        end else begin
            fn_r <= 1'b0;
            act_r <= 1'b0;
            inact_r <= 1'b0;
            full_r <= 1'b0;
            empty_r <= 1'b0;
            ev <= 3'h0;
            case (st_r)
                tpm_pp_idle: begin
                    if (wr && addr == tpm_pkg::tpm_reg_ctrl) begin
                        out_r <= wdata[11:0];
                        busy_r <= 1'b1;
                        stopped_r <= 1'b0;
                        case (tpm_pkg::tpm_cmd_type'(cmd))
                            tpm_pkg::tpm_cmd_function: begin
                                fn_r <= 1'b1;
                                st_r <= tpm_pp_wait_ack;
                            end
                            tpm_pkg::tpm_cmd_input: begin
                                act_r <= 1'b1;
                                st_r <= tpm_pp_wait_in;
                            end
                            tpm_pkg::tpm_cmd_output: begin
                                act_r <= 1'b1;
                                st_r <= tpm_pp_idle;
                                busy_r <= 1'b0;
                            end
                            default: begin
                                inact_r <= 1'b1;
                                busy_r <= 1'b0;
                                ev[tpm_pkg::tpm_irq_done] <= 1'b1;
                            end
                        endcase
                    end else if (wr && addr == tpm_pkg::tpm_reg_wdata) begin
                        out_r <= wdata[11:0];
                        full_r <= 1'b1;
                        busy_r <= 1'b1;
                        st_r <= tpm_pp_wait_out;
                    end
                end
                tpm_pp_wait_ack: if (chan.inactive_mux) begin
                    busy_r <= 1'b0;
                    st_r <= tpm_pp_idle;
                    ev[tpm_pkg::tpm_irq_done] <= 1'b1;
                end
                tpm_pp_wait_in: if (chan.full_mux) begin
                    in_r <= chan.data_mux;
                    empty_r <= 1'b1;
                    busy_r <= 1'b0;
                    st_r <= tpm_pp_idle;
                    ev[tpm_pkg::tpm_irq_input] <= 1'b1;
                end
                tpm_pp_wait_out: if (chan.empty_mux || chan.inactive_mux) begin
                    busy_r <= 1'b0;
                    stopped_r <= chan.inactive_mux;
                    st_r <= tpm_pp_idle;
                    ev[tpm_pkg::tpm_irq_done] <= 1'b1;
                    ev[tpm_pkg::tpm_irq_stop] <= chan.inactive_mux;
                end
                default: st_r <= tpm_pp_idle;
            endcase
            // an ignored code never answers: a disconnect frees the sequencer
            if (wr && addr == tpm_pkg::tpm_reg_ctrl && st_r != tpm_pp_idle &&
                tpm_pkg::tpm_cmd_type'(cmd) == tpm_pkg::tpm_cmd_disconnect) begin
                inact_r <= 1'b1;
                busy_r <= 1'b0;
                st_r <= tpm_pp_idle;
                ev[tpm_pkg::tpm_irq_done] <= 1'b1;
            end
        end
    end
    assign chan.data_pp = out_r;
    assign chan.function_p = fn_r;
    assign chan.active_p = act_r;
    assign chan.inactive_pp = inact_r;
    assign chan.full_pp = full_r;
    assign chan.empty_pp = empty_r;

    ////////////////////////////////////////////////////////////////
    // interrupt status, set wins over write-one clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_stat_r <= 3'h0;
            irq_mask_r <= tpm_pkg::tpm_irq_mask_reset;
        end else begin
            if (wr && addr == tpm_pkg::tpm_reg_irq_stat)
                irq_stat_r <= (irq_stat_r & ~wdata[2:0]) | ev;
            else
                irq_stat_r <= irq_stat_r | ev;
            if (wr && addr == tpm_pkg::tpm_reg_irq_mask)
                irq_mask_r <= wdata[2:0];
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                tpm_pkg::tpm_reg_status: rdata <= {29'h0, stopped_r, chan.mux_drive, busy_r};
                tpm_pkg::tpm_reg_rdata: rdata <= {20'h00000, in_r};
                tpm_pkg::tpm_reg_irq_stat: rdata <= {29'h0, irq_stat_r};
                tpm_pkg::tpm_reg_irq_mask: rdata <= {29'h0, irq_mask_r};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule

/* File: bench/tpm_chan_asserts.sv */
// checker of the channel between the processor end and the multiplexer end
// assumes one clock for both ends and the interface signals wired in as plain inputs
`timescale 1ns/10ps
module tpm_chan_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [11:0] data_pp,
    input wire logic [11:0] data_mux,
    input wire logic data_mux_oe,
    input wire logic function_p,
    input wire logic active_p,
    input wire logic inactive_pp,
    input wire logic full_pp,
    input wire logic empty_pp,
    input wire logic inactive_mux,
    input wire logic full_mux,
    input wire logic empty_mux,
    input wire logic mux_drive
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic acked;
    logic is_select;
    // a select is heard even while deselected, deselect and operation codes only while selected
    assign acked = (data_pp[11:9] == tpm_pkg::tpm_terminal_select_code) || (mux_drive
        && (data_pp[11:9] == tpm_pkg::tpm_terminal_deselect_code
        || data_pp[11:9] == tpm_pkg::tpm_operation_code));
    assign is_select = data_pp == tpm_pkg::tpm_select_port0 ||
        data_pp == tpm_pkg::tpm_select_port1;
    ////////////////////////////////////////////////////////////////////////////
    chk_func_ack: assert property (function_p && acked |=> inactive_mux)
        else $error("function code not acknowledged");
    chk_func_ignore: assert property (function_p && !acked |=> !inactive_mux)
        else $error("ignored function code acknowledged");
    chk_select_on: assert property (function_p && is_select |-> ##[1:2] mux_drive)
        else $error("select did not connect");
    chk_deselect_off: assert property (function_p && mux_drive
        && data_pp[11:9] == tpm_pkg::tpm_terminal_deselect_code |-> ##[1:2] !mux_drive)
        else $error("deselect left channel held");
    chk_full_cause: assert property (full_mux |-> $past(active_p) && data_mux_oe)
        else $error("input word without activate");
    chk_oe_release: assert property (data_mux_oe && (empty_pp || inactive_pp)
        |=> !data_mux_oe)
        else $error("data still driven after word taken");
    chk_empty_cause: assert property (empty_mux |-> $past(full_pp))
        else $error("empty without output word");
    chk_word_answer: assert property (full_pp && mux_drive |=> empty_mux ^ inactive_mux)
        else $error("output word not answered");
    chk_idle_quiet: assert property (!mux_drive && !$past(mux_drive)
        |-> !data_mux_oe && !full_mux && !empty_mux)
        else $error("deselected end drives channel");
endmodule

/* File: bench/tb_two_port_terminal_mux_channel.sv */
// self-checking bench: processor end and multiplexer end joined by the channel
// assumes a 10 MHz clock and the register map of the package
`timescale 1ns/10ps
module tb_two_port_terminal_mux_channel;
    logic ref_clk, rst, wr, rd, irq, port_sel;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, r;
    logic [1:0] dsr, dcd, ring, tx_valid, tx_ready;
    logic rx_valid, rx_frame_err, rx_parity_err;
    logic [7:0] rx_char, tx_char;
    int failures, n_checks, k;
    tpm_chan_if chan ();
    tpm_mux u_tpm_mux (.ref_clk(ref_clk), .rst(rst), .chan(chan), .dsr(dsr), .dcd(dcd),
        .ring(ring), .rx_valid(rx_valid), .rx_char(rx_char), .rx_frame_err(rx_frame_err),
        .rx_parity_err(rx_parity_err), .tx_valid(tx_valid), .tx_char(tx_char),
        .tx_ready(tx_ready), .port_sel(port_sel));
    tpm_pp u_tpm_pp (.ref_clk(ref_clk), .rst(rst), .chan(chan), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    tpm_chan_asserts u_tpm_chan_asserts (.ref_clk(ref_clk), .rst(rst),
        .data_pp(chan.data_pp), .data_mux(chan.data_mux), .data_mux_oe(chan.data_mux_oe),
        .function_p(chan.function_p), .active_p(chan.active_p),
        .inactive_pp(chan.inactive_pp), .full_pp(chan.full_pp), .empty_pp(chan.empty_pp),
        .inactive_mux(chan.inactive_mux), .full_mux(chan.full_mux),
        .empty_mux(chan.empty_mux), .mux_drive(chan.mux_drive));
    ////////////////////////////////////////////////////////////////////////////
    task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        // let the edge that took the write settle before anyone looks
        @(negedge ref_clk);
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask
    // bounded poll; a refused code leaves busy set, which callers check
    task automatic wait_idle();
        repeat (20) begin
            reg_rd(tpm_pkg::tpm_reg_status, r);
            if (r[0] === 1'b0) break;
        end
    endtask
    task automatic cmd(input logic [1:0] c, input logic [11:0] w);
        reg_wr(tpm_pkg::tpm_reg_ctrl, {18'h0, c, w});
        wait_idle();
    endtask
    task automatic rx_put(input logic [7:0] ch, input logic fe, input logic pe);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_char <= ch;
        rx_frame_err <= fe;
        rx_parity_err <= pe;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_frame_err <= 1'b0;
        rx_parity_err <= 1'b0;
    endtask
    task automatic read_word(input logic [11:0] code, input logic [31:0] exp, input string what);
        cmd(tpm_pkg::tpm_cmd_function, code);
        cmd(tpm_pkg::tpm_cmd_input, 12'h000);
        reg_rd(tpm_pkg::tpm_reg_rdata, r);
        compare(r, exp, what);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_select_irq();
        cmd(tpm_pkg::tpm_cmd_function, tpm_pkg::tpm_select_port1);
        compare({30'h0, r[1:0]}, 32'h2, "status after select");
        compare({31'h0, port_sel}, 32'h1, "port after select");
        reg_rd(tpm_pkg::tpm_reg_irq_mask, r);
        compare(r, 32'h0, "mask reset");
        reg_rd(tpm_pkg::tpm_reg_irq_stat, r);
        compare({31'h0, r[tpm_pkg::tpm_irq_done]}, 32'h1, "done event");
        // a mask bit of one lets its status bit through
        compare({31'h0, irq}, 32'h0, "masked irq");
        reg_wr(tpm_pkg::tpm_reg_irq_mask, 32'h7);
        compare({31'h0, irq}, 32'h1, "unmasked irq");
        reg_wr(tpm_pkg::tpm_reg_irq_stat, 32'h7);
        reg_rd(tpm_pkg::tpm_reg_irq_stat, r);
        compare({31'h0, irq}, 32'h0, "irq after clear");
        compare(r, 32'h0, "stat after clear");
        reg_rd(4'hf, r);
        compare(r, 32'h0, "unmapped read");
    endtask
    // two characters unread: the second overwrites and flags overrun
    task automatic t_input();
        dsr <= 2'b10;
        dcd <= 2'b10;
        ring <= 2'b10;
        rx_put(8'hc3, 1'b1, 1'b0);
        rx_put(8'h3c, 1'b0, 1'b1);
        repeat (4) @(posedge ref_clk);
        read_word(12'h000, 32'h01f, "status word");
        read_word(12'h040, 32'hf3c, "data word overrun");
        dcd <= 2'b00;
        rx_put(8'ha5, 1'b0, 1'b0);
        repeat (4) @(posedge ref_clk);
        read_word(12'h040, 32'h8a5, "data word clean");
    endtask
    // buffer filled while the uart stalls, then drained
    task automatic t_output();
        cmd(tpm_pkg::tpm_cmd_function, 12'h080);
        cmd(tpm_pkg::tpm_cmd_output, 12'h000);
        for (int i = 0; i < 64; i++) begin
            reg_wr(tpm_pkg::tpm_reg_wdata, {24'h0, 8'(i) ^ 8'h5a});
            wait_idle();
            if (i == 62) compare({31'h0, r[2]}, 32'h0, "stopped early");
        end
        compare({31'h0, r[2]}, 32'h1, "stopped on last slot");
        compare({30'h0, tx_valid}, 32'h2, "tx valid");
        compare({24'h0, tx_char}, 32'h5a, "buffer head");
        @(posedge ref_clk);
        tx_ready <= 2'b10;
        k = 0;
        // looked at mid-cycle: a character leaves at the next rising edge
        repeat (300) begin
            @(negedge ref_clk);
            if (tx_valid[1] === 1'b1 && tx_ready[1] === 1'b1) begin
                compare({24'h0, tx_char}, {24'h0, 8'(k) ^ 8'h5a}, "drained char");
                k++;
            end
        end
        compare(k, 32'd64, "drained count");
        tx_ready <= 2'b00;
    endtask
    task automatic t_refuse();
        cmd(tpm_pkg::tpm_cmd_function, 12'h600);
        compare({31'h0, r[0]}, 32'h1, "odd code acked");
        cmd(tpm_pkg::tpm_cmd_disconnect, 12'h000);
        compare({31'h0, r[0]}, 32'h0, "busy after abort");
        cmd(tpm_pkg::tpm_cmd_function, 12'hc00);
        compare({31'h0, r[1]}, 32'h0, "held after deselect");
        cmd(tpm_pkg::tpm_cmd_function, 12'h000);
        compare({31'h0, r[0]}, 32'h1, "deselected end answered");
        cmd(tpm_pkg::tpm_cmd_disconnect, 12'h000);
        cmd(tpm_pkg::tpm_cmd_function, tpm_pkg::tpm_select_port0);
        compare({30'h0, port_sel, r[1]}, 32'h1, "port 0 select");
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #(30000 * 100);
        failures++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        {wr, rd, addr, wdata} = '0;
        {dsr, dcd, ring, tx_ready} = '0;
        {rx_valid, rx_char, rx_frame_err, rx_parity_err} = '0;
        failures = 0;
        n_checks = 0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_select_irq();
        t_input();
        t_output();
        t_refuse();
        conclude();
    end
endmodule
